// ===== common/dcd_if.sv
`timescale 1ns/10ps
interface dcd_if;
	logic                          clk_true;
	logic                          clk_comp;
	logic                          cs_n;
	logic                          ras_n;
	logic                          cas_n;
	logic                          we_n;
	logic [dcd_pkg::BANK_W-1:0]    bank_sel;
	logic [dcd_pkg::ADDR_W-1:0]    addr;
	logic                          termination_ctl;
	logic [1:0]                    write_mask;
	logic [dcd_pkg::DQ_W-1:0]      dq_ctl;
	logic [dcd_pkg::DQ_W-1:0]      dq_dev;
	logic                          dq_dev_oe;
	logic [1:0]                    strobe_dev;
	logic                          strobe_dev_oe;

	modport dev (
		input  clk_true, clk_comp, cs_n, ras_n, cas_n, we_n, bank_sel, addr,
		input  termination_ctl, write_mask, dq_ctl,
		output dq_dev, dq_dev_oe, strobe_dev, strobe_dev_oe
	);
	modport ctl (
		output clk_true, clk_comp, cs_n, ras_n, cas_n, we_n, bank_sel, addr,
		output termination_ctl, write_mask, dq_ctl,
		input  dq_dev, dq_dev_oe, strobe_dev, strobe_dev_oe
	);
endinterface

// ===== common/dcd_pkg.sv
package dcd_pkg;
	localparam int ADDR_W     = 14;
	localparam int BANK_W     = 3;
	localparam int NUM_BANKS  = 8;
	localparam int DQ_W       = 16;
	localparam int BYTE_W     = 8;
	localparam int COL_W      = 10;
	localparam int AP_BIT     = 10;
	// extended register one: termination enable bits
	localparam int ODT_EN_LO  = 2;
	localparam int ODT_EN_HI  = 6;
	// mode register targets on the bank-select inputs
	localparam logic [2:0] SEL_MAIN  = 3'h0;
	localparam logic [2:0] SEL_EXT1  = 3'h1;
	localparam logic [2:0] SEL_EXT2  = 3'h2;
	localparam logic [2:0] SEL_EXT3  = 3'h3;
	// ext reg two: high-temperature self refresh bit
	localparam int HTSR_BIT   = 7;
	localparam logic [13:0] MODE_RST = 14'h0000;
	// controller link clock divider (half period in clk_i cycles)
	localparam int LINK_HALF  = 4;
	localparam int REF_NORMAL = 16;
	localparam int REF_HOT    = REF_NORMAL / 2;
	// {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DES = 4'h8;

	typedef enum logic [2:0] {
		DCD_OP_NONE,
		DCD_OP_ACT,
		DCD_OP_RD,
		DCD_OP_WR,
		DCD_OP_PRE,
		DCD_OP_MRS,
		DCD_OP_REF
	} dcd_op_t;
endpackage

// ===== dv/dcd_checker.sv
`timescale 1ns/10ps
module dcd_checker (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        clk_true,
	input  wire logic        clk_comp,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  bank_sel,
	input  wire logic [13:0] addr,
	input  wire logic [1:0]  write_mask
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_clk_pair: assert property (clk_comp != clk_true)
		else $error("link clock pair not complementary");
	// half period of four clk_i cycles
	a_high_half: assert property ($rose(clk_true) |-> ##4 $fell(clk_true))
		else $error("link clock high phase wrong");
	a_low_half: assert property ($fell(clk_true) |-> ##4 $rose(clk_true))
		else $error("link clock low phase wrong");
	a_cmd_hold: assert property (
		$rose(clk_true) |-> $stable({cs_n, ras_n, cas_n, we_n})[*3])
		else $error("command pins moved around rising edge");
	a_addr_hold: assert property (
		$rose(clk_true) |-> $stable({bank_sel, addr})[*3])
		else $error("bank or address moved around rising edge");
	a_cmd_low: assert property (
		$changed({cs_n, ras_n, cas_n, we_n}) |-> !clk_true)
		else $error("command pins changed with clock high");
	a_addr_low: assert property ($changed({bank_sel, addr}) |-> !clk_true)
		else $error("bank or address changed with clock high");
	a_reset_idle: assert property (
		$rose(rstn_i) |-> cs_n && write_mask == 2'h3 && !clk_true)
		else $error("link not idle after reset");
endmodule

// ===== dv/test_ddr2_cmd_addr_decode.sv
`timescale 1ns/10ps
module test_ddr2_cmd_addr_decode;
	logic        clk_i       = 1'b0;
	logic        rstn_i      = 1'b0;
	logic        cmd_valid_i = 1'b0;
	logic [3:0]  cmd_i       = 4'h7;
	logic [2:0]  bank_i      = 3'h0;
	logic [13:0] addr_i      = 14'h0000;
	logic        term_i      = 1'b0;
	logic [15:0] wdata_i     = 16'h0000;
	logic [1:0]  wmask_i     = 2'h3;
	logic        hot_i       = 1'b0;
	logic [15:0] rd_data_i   = 16'h0000;
	logic        rd_drive_i  = 1'b0;
	logic        cmd_ready_o, refresh_due_o, htsr_needed_o, op_valid_o;
	logic        auto_pre_o, pre_all_o, term_on_o, wr_data_valid_o;
	logic [2:0]  op_o, bank_o;
	logic [13:0] row_o, main_mode_reg_o, ext_mode_reg_one_o;
	logic [13:0] ext_mode_reg_two_o, ext_mode_reg_three_o;
	logic [9:0]  col_o;
	logic [7:0]  bank_open_o;
	logic [15:0] wr_data_o;
	int          errors      = 0;
	int          n_compared  = 0;
	int          g;

	dcd_if link ();
	dcd_device dcd_device_i (.clk_i, .rstn_i, .link(link), .op_o, .op_valid_o, .bank_o,
		.row_o, .col_o, .auto_pre_o, .pre_all_o, .bank_open_o, .main_mode_reg_o,
		.ext_mode_reg_one_o, .ext_mode_reg_two_o, .ext_mode_reg_three_o, .term_on_o,
		.wr_data_o, .wr_data_valid_o, .rd_data_i, .rd_drive_i);
	dcd_controller dcd_controller_i (.clk_i, .rstn_i, .link(link), .cmd_valid_i,
		.cmd_ready_o, .cmd_i, .bank_i, .addr_i, .term_i, .wdata_i, .wmask_i, .hot_i,
		.refresh_due_o, .htsr_needed_o);
	dcd_checker dcd_checker_i (.clk_i, .rstn_i, .clk_true(link.clk_true),
		.clk_comp(link.clk_comp), .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n), .bank_sel(link.bank_sel),
		.addr(link.addr), .write_mask(link.write_mask));

	always #2 clk_i = ~clk_i;

	task complete_run;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// bounded wait, sampled mid-cycle
	task automatic wait_on(ref logic s, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (s !== 1'b1 && n < lim);
		if (s !== 1'b1) begin
			errors++;
			complete_run();
		end
	endtask

	task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		@(posedge clk_i);
		cmd_i       <= c;
		bank_i      <= b;
		addr_i      <= a;
		cmd_valid_i <= 1'b1;
		wait_on(cmd_ready_o, 40);
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		wait_on(link.clk_true, 40);
		check(16'({link.cs_n, link.ras_n, link.cas_n, link.we_n}), 16'(c));
		check(16'(link.bank_sel), 16'(b));
		check(16'(link.addr), 16'(a));
	endtask

	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		send(c, b, a);
		wait_on(op_valid_o, 40);
	endtask

	task automatic gap;
		wait_on(refresh_due_o, 300);
		g = 0;
		do begin
			@(negedge clk_i);
			g++;
		end while (refresh_due_o !== 1'b1 && g < 300);
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		issue(dcd_pkg::CMD_ACT, 3'h5, 14'h2A5C);
		check(16'(op_o), 16'(dcd_pkg::DCD_OP_ACT));
		check(16'(bank_o), 16'h0005);
		check(16'(row_o), 16'h2A5C);
		issue(dcd_pkg::CMD_ACT, 3'h1, 14'h0001);
		// bit ten set: auto-precharge, column 155
		issue(dcd_pkg::CMD_RD, 3'h5, 14'h0555);
		check(16'(op_o), 16'(dcd_pkg::DCD_OP_RD));
		check(16'(col_o), 16'h0155);
		check(16'(auto_pre_o), 16'h0001);
		@(negedge clk_i);
		check(16'(bank_open_o), 16'h0002);
		issue(dcd_pkg::CMD_ACT, 3'h3, 14'h0100);
		@(posedge clk_i);
		wdata_i <= 16'hBEEF;
		wmask_i <= 2'h2;
		issue(dcd_pkg::CMD_WR, 3'h3, 14'h03FF);
		check(16'(op_o), 16'(dcd_pkg::DCD_OP_WR));
		check(16'(col_o), 16'h03FF);
		check(16'(auto_pre_o), 16'h0000);
		check(16'(bank_o), 16'h0003);
		wait_on(wr_data_valid_o, 40);
		check(wr_data_o, 16'h00EF);
		issue(dcd_pkg::CMD_PRE, 3'h3, 14'h0000);
		check(16'(pre_all_o), 16'h0000);
		@(negedge clk_i);
		check(16'(bank_open_o), 16'h0002);
		issue(dcd_pkg::CMD_PRE, 3'h0, 14'h0400);
		check(16'(pre_all_o), 16'h0001);
		@(negedge clk_i);
		check(16'(bank_open_o), 16'h0000);
		for (int i = 0; i < 4; i++)
			issue(dcd_pkg::CMD_MRS, 3'(i), 14'h1000 + 14'(i));
		send(dcd_pkg::CMD_MRS, 3'h4, 14'h3FFF);
		repeat (16) @(negedge clk_i);
		check(16'(main_mode_reg_o), 16'h1000);
		check(16'(ext_mode_reg_one_o), 16'h1001);
		check(16'(ext_mode_reg_two_o), 16'h1002);
		check(16'(ext_mode_reg_three_o), 16'h1003);
		// chip select high: activate must be masked
		@(posedge clk_i);
		term_i <= 1'b1;
		send(4'hB, 3'h2, 14'h0000);
		g = 0;
		repeat (24) begin
			@(negedge clk_i);
			g += int'(op_valid_o === 1'b1);
		end
		check(16'(g), 16'h0000);
		check(16'(term_on_o), 16'h0000);
		issue(dcd_pkg::CMD_MRS, dcd_pkg::SEL_EXT1, 14'h0004);
		wait_on(term_on_o, 40);
		check(16'(term_on_o), 16'h0001);
		@(posedge clk_i);
		rd_data_i  <= 16'h1234;
		rd_drive_i <= 1'b1;
		wait_on(link.dq_dev_oe, 40);
		check(link.dq_dev, 16'h1234);
		// both strobes high for the half period after each rise
		g = 0;
		repeat (2 * dcd_pkg::LINK_HALF) begin
			@(negedge clk_i);
			g += int'(link.strobe_dev === 2'h3 && link.strobe_dev_oe === 1'b1);
		end
		check(16'(g), 16'(dcd_pkg::LINK_HALF));
		gap();
		check(16'(g), 16'(2 * dcd_pkg::LINK_HALF * dcd_pkg::REF_NORMAL));
		@(posedge clk_i);
		hot_i <= 1'b1;
		gap();
		gap();
		check(16'(g), 16'(2 * dcd_pkg::LINK_HALF * dcd_pkg::REF_HOT));
		check(16'(htsr_needed_o), 16'h0001);
		complete_run();
	end
endmodule

// ===== rtl/dcd_controller.sv
`timescale 1ns/10ps
module dcd_controller (
	input  wire logic                          clk_i,
	input  wire logic                          rstn_i,
	dcd_if.ctl                                 link,
	input  wire logic                          cmd_valid_i,
	output logic                               cmd_ready_o,
	input  wire logic [3:0]                    cmd_i,
	input  wire logic [dcd_pkg::BANK_W-1:0]    bank_i,
	input  wire logic [dcd_pkg::ADDR_W-1:0]    addr_i,
	input  wire logic                          term_i,
	input  wire logic [dcd_pkg::DQ_W-1:0]      wdata_i,
	input  wire logic [1:0]                    wmask_i,
	input  wire logic                          hot_i,
	output logic                               refresh_due_o,
	output logic                               htsr_needed_o
);
	logic [3:0] div_r;
	logic       ck_r;
	logic [4:0] tick_r;
	logic       edge_due;
	logic       fall_due;

	assign edge_due = (div_r == 4'(dcd_pkg::LINK_HALF - 1));
	assign fall_due = edge_due & ck_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			div_r <= 4'h0;
			ck_r  <= 1'b0;
		end else if (edge_due) begin
			div_r <= 4'h0;
			ck_r  <= ~ck_r;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// new command launched at falling edge, stable around rising edge
	assign cmd_ready_o = fall_due;

	logic [3:0]                 cmd_r;
	logic [dcd_pkg::BANK_W-1:0] bank_r;
	logic [dcd_pkg::ADDR_W-1:0] addr_r;
	logic                       odt_r;
	logic [dcd_pkg::DQ_W-1:0]   wd_r;
	logic [1:0]                 wm_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cmd_r  <= dcd_pkg::CMD_DES;
			bank_r <= '0;
			addr_r <= '0;
			odt_r  <= 1'b0;
			wd_r   <= '0;
			wm_r   <= 2'h3;
		end else if (fall_due) begin
			cmd_r  <= cmd_valid_i ? cmd_i : dcd_pkg::CMD_NOP;
			bank_r <= bank_i;
			addr_r <= addr_i;
			odt_r  <= term_i;
			wd_r   <= wdata_i;
			wm_r   <= wmask_i;
		end
	end

	// refresh interval halves when hot
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tick_r        <= 5'h0;
			refresh_due_o <= 1'b0;
		end else if (fall_due) begin
			if (tick_r >= 5'(hot_i ? dcd_pkg::REF_HOT : dcd_pkg::REF_NORMAL) - 5'h1) begin
				tick_r        <= 5'h0;
				refresh_due_o <= 1'b1;
			end else begin
				tick_r        <= tick_r + 5'h1;
				refresh_due_o <= 1'b0;
			end
		end else begin
			refresh_due_o <= 1'b0;
		end
	end

	// flag: self refresh needs high-temp bit first
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			htsr_needed_o <= 1'b0;
		end else begin
			htsr_needed_o <= hot_i;
		end
	end

	assign link.clk_true        = ck_r;
	assign link.clk_comp        = ~ck_r;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_r;
	assign link.bank_sel        = bank_r;
	assign link.addr            = addr_r;
	assign link.termination_ctl = odt_r;
	assign link.write_mask      = wm_r;
	assign link.dq_ctl          = wd_r;
endmodule

// ===== rtl/dcd_device.sv
`timescale 1ns/10ps
//Contract
// - controller doubles refresh rate above 85C
// - controller enables high-temp self refresh when hot (controller only raises htsr_needed_o, never writes HTSR_BIT)
// - low byte uses lower mask/strobe, high upper
// - row on activate, column on read/write
// - address bit ten is auto-precharge on access
// - precharge one bank or all by bit ten
// - mode load takes op-code from address
// - bank-select picks one of eight banks
// - bank-select picks mode register on load
// - sample inputs on true-clock rising crossing
// - read data timed to clock crossings
// - controller keeps delay-locked loop enabled (controller has no DLL logic; mode-load op-codes pass from addr_i unchanged)
// - chip select high masks every command
// - command from strobes, write-enable, chip select
// - termination input ignored when disabled
module dcd_device (
	input  wire logic                          clk_i,
	input  wire logic                          rstn_i,
	dcd_if.dev                                 link,
	output logic     [2:0]                     op_o,
	output logic                               op_valid_o,
	output logic     [dcd_pkg::BANK_W-1:0]     bank_o,
	output logic     [dcd_pkg::ADDR_W-1:0]     row_o,
	output logic     [dcd_pkg::COL_W-1:0]      col_o,
	output logic                               auto_pre_o,
	output logic                               pre_all_o,
	output logic     [dcd_pkg::NUM_BANKS-1:0]  bank_open_o,
	output logic     [dcd_pkg::ADDR_W-1:0]     main_mode_reg_o,
	output logic     [dcd_pkg::ADDR_W-1:0]     ext_mode_reg_one_o,
	output logic     [dcd_pkg::ADDR_W-1:0]     ext_mode_reg_two_o,
	output logic     [dcd_pkg::ADDR_W-1:0]     ext_mode_reg_three_o,
	output logic                               term_on_o,
	output logic     [dcd_pkg::DQ_W-1:0]       wr_data_o,
	output logic                               wr_data_valid_o,
	input  wire logic [dcd_pkg::DQ_W-1:0]      rd_data_i,
	input  wire logic                          rd_drive_i
);
	// two-flop synchronisers for all link inputs
	localparam int SW = 4 + 2 + dcd_pkg::BANK_W + dcd_pkg::ADDR_W + 1 + 2 + dcd_pkg::DQ_W;
	logic [SW-1:0] meta_r;
	logic [SW-1:0] sync_r;
	logic          ck_prev_r;
	logic          ck_t;
	logic          ck_c;
	logic [3:0]    cmd;
	logic [dcd_pkg::BANK_W-1:0] ba;
	logic [dcd_pkg::ADDR_W-1:0] a;
	logic          odt_in;
	logic [1:0]    dm;
	logic [dcd_pkg::DQ_W-1:0] dq;
	logic          rise;
	logic          fall;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {link.cs_n, link.ras_n, link.cas_n, link.we_n, link.clk_true,
				link.clk_comp, link.bank_sel, link.addr, link.termination_ctl,
				link.write_mask, link.dq_ctl};
			sync_r <= meta_r;
		end
	end

	assign {cmd, ck_t, ck_c, ba, a, odt_in, dm, dq} = sync_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ck_prev_r <= 1'b0;
		end else begin
			ck_prev_r <= ck_t;
		end
	end

	// true clock rising while complement low
	assign rise = ck_t & ~ck_c & ~ck_prev_r;
	assign fall = ~ck_t & ck_c & ck_prev_r;

	function automatic dcd_pkg::dcd_op_t decode(input logic [3:0] c);
		case (c)
			dcd_pkg::CMD_ACT: decode = dcd_pkg::DCD_OP_ACT;
			dcd_pkg::CMD_RD:  decode = dcd_pkg::DCD_OP_RD;
			dcd_pkg::CMD_WR:  decode = dcd_pkg::DCD_OP_WR;
			dcd_pkg::CMD_PRE: decode = dcd_pkg::DCD_OP_PRE;
			dcd_pkg::CMD_MRS: decode = dcd_pkg::DCD_OP_MRS;
			dcd_pkg::CMD_REF: decode = dcd_pkg::DCD_OP_REF;
			default:          decode = dcd_pkg::DCD_OP_NONE;
		endcase
	endfunction

	dcd_pkg::dcd_op_t op;
	assign op = cmd[3] ? dcd_pkg::DCD_OP_NONE : decode(cmd);

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			op_o       <= 3'h0;
			op_valid_o <= 1'b0;
			bank_o     <= '0;
			row_o      <= '0;
			col_o      <= '0;
			auto_pre_o <= 1'b0;
			pre_all_o  <= 1'b0;
		end else begin
			op_valid_o <= 1'b0;
			if (rise && op != dcd_pkg::DCD_OP_NONE) begin
				op_o       <= op;
				op_valid_o <= 1'b1;
				bank_o     <= ba;
				auto_pre_o <= 1'b0;
				pre_all_o  <= 1'b0;
				if (op == dcd_pkg::DCD_OP_ACT) begin
					row_o <= a;
				end
				if (op == dcd_pkg::DCD_OP_RD || op == dcd_pkg::DCD_OP_WR) begin
					col_o      <= a[dcd_pkg::COL_W-1:0];
					auto_pre_o <= a[dcd_pkg::AP_BIT];
				end
				if (op == dcd_pkg::DCD_OP_PRE) begin
					pre_all_o <= a[dcd_pkg::AP_BIT];
				end
			end
		end
	end

	// open-row tracking per bank
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			bank_open_o <= '0;
		end else if (rise) begin
			case (op)
				dcd_pkg::DCD_OP_ACT: bank_open_o[ba] <= 1'b1;
				dcd_pkg::DCD_OP_PRE: begin
					if (a[dcd_pkg::AP_BIT]) begin
						bank_open_o <= '0;
					end else begin
						bank_open_o[ba] <= 1'b0;
					end
				end
				dcd_pkg::DCD_OP_RD, dcd_pkg::DCD_OP_WR: begin
					if (a[dcd_pkg::AP_BIT]) begin
						bank_open_o[ba] <= 1'b0;
					end
				end
				default: bank_open_o <= bank_open_o;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			main_mode_reg_o      <= dcd_pkg::MODE_RST;
			ext_mode_reg_one_o   <= dcd_pkg::MODE_RST;
			ext_mode_reg_two_o   <= dcd_pkg::MODE_RST;
			ext_mode_reg_three_o <= dcd_pkg::MODE_RST;
		end else if (rise && op == dcd_pkg::DCD_OP_MRS) begin
			case (ba)
				dcd_pkg::SEL_MAIN: main_mode_reg_o      <= a;
				dcd_pkg::SEL_EXT1: ext_mode_reg_one_o   <= a;
				dcd_pkg::SEL_EXT2: ext_mode_reg_two_o   <= a;
				dcd_pkg::SEL_EXT3: ext_mode_reg_three_o <= a;
				default:           main_mode_reg_o      <= main_mode_reg_o;
			endcase
		end
	end

	logic odt_enabled;
	assign odt_enabled = ext_mode_reg_one_o[dcd_pkg::ODT_EN_LO]
		| ext_mode_reg_one_o[dcd_pkg::ODT_EN_HI];

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			term_on_o <= 1'b0;
		end else if (rise) begin
			term_on_o <= odt_in & odt_enabled;
		end
	end

	// write capture: per-byte masks
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_data_o       <= '0;
			wr_data_valid_o <= 1'b0;
		end else begin
			wr_data_valid_o <= 1'b0;
			if (rise || fall) begin
				wr_data_valid_o <= ~&dm;
				if (!dm[0]) begin
					wr_data_o[dcd_pkg::BYTE_W-1:0] <= dq[dcd_pkg::BYTE_W-1:0];
				end
				if (!dm[1]) begin
					wr_data_o[dcd_pkg::DQ_W-1:dcd_pkg::BYTE_W] <=
						dq[dcd_pkg::DQ_W-1:dcd_pkg::BYTE_W];
				end
			end
		end
	end

	// read drive launched at clock crossings
	logic [dcd_pkg::DQ_W-1:0] dq_out_r;
	logic                     oe_r;
	logic [1:0]               strobe_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dq_out_r <= '0;
			oe_r     <= 1'b0;
			strobe_r <= 2'h0;
		end else if (rise || fall) begin
			dq_out_r <= rd_data_i;
			oe_r     <= rd_drive_i;
			strobe_r <= (rd_drive_i && rise) ? 2'h3 : 2'h0;
		end
	end

	assign link.dq_dev        = dq_out_r;
	assign link.dq_dev_oe     = oe_r;
	assign link.strobe_dev    = strobe_r;
	assign link.strobe_dev_oe = oe_r;
endmodule
